/* File: hw/uqr_core.sv */
// Receive queue controller: moves UART bytes into internal RAM
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module uqr_core #(
  parameter int AW = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [uqr_pkg::UQR_AW-1:0] i_addr,
  input wire logic [uqr_pkg::UQR_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [uqr_pkg::UQR_DW-1:0] o_rdata,
  input wire logic i_rx_char,
  input wire logic [7:0] i_uart_rx_holding,
  output logic o_rx_fetch,
  output logic o_ram_we,
  output logic [AW-1:0] o_ram_addr,
  output logic [7:0] o_ram_wdata,
  input wire logic i_emul_freeze_n,
  output logic o_rx_done_flag,
  output logic o_rx_run_flag,
  output logic o_rx_waiting,
  output logic o_irq
);
  import uqr_pkg::*;

  typedef struct packed {
    uqr_state_e st;
    logic run;
    logic en;
    logic match_en;
    logic ovr_en;
    logic wrap_en;
    logic pbyte_en;
    logic pause_ctl;
    logic pause_bit;
    logic [AW-1:0] addr;
    logic [AW-1:0] base;
    logic [7:0] count;
    logic [7:0] len;
    logic [7:0] match;
    logic pending;
    // Wait entered from idle returns to idle, not to the count test
    logic from_idle;
    logic fetch;
    logic ram_we;
    logic [AW-1:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [UQR_DW-1:0] rdata;
  } uqr_core_s;

  localparam uqr_core_s UQR_CORE_RST = '{
    st: UQR_IDLE,
    run: UQR_CTRL_RST[UQR_CTL_RUN],
    en: UQR_CTRL_RST[UQR_CTL_EN],
    match_en: UQR_CTRL_RST[UQR_CTL_MATCH],
    ovr_en: UQR_CTRL_RST[UQR_CTL_OVR],
    wrap_en: UQR_CTRL_RST[UQR_CTL_WRAP],
    pbyte_en: UQR_CTRL_RST[UQR_CTL_PBYTE],
    pause_ctl: UQR_CTRL_RST[UQR_CTL_PCTL],
    addr: AW'(UQR_ADDR_RST),
    base: AW'(UQR_ADDR_RST),
    count: UQR_COUNT_RST,
    len: UQR_COUNT_RST,
    match: UQR_MATCH_RST,
    default: '0
  };

  uqr_core_s s;
  uqr_core_s next_s;

  logic pause;
  logic take;
  logic is_match;
  logic [UQR_NEV-1:0] ev;
  logic [UQR_NEV-1:0] ev_clr;
  logic mask_we;
  logic [UQR_NEV-1:0] status;
  logic [UQR_NEV-1:0] mask;

  // Address and count step; shared by pointer and length counter
  function automatic logic [7:0] uqr_step(input logic [7:0] v, input logic up);
    logic [8:0] r;
    r = up ? ({1'b0, v} + 9'h001) : ({1'b0, v} - 9'h001);
    return r[7:0];
  endfunction : uqr_step

  // Control register image, used for readback
  function automatic logic [UQR_DW-1:0] uqr_ctrl_pack(input uqr_core_s c);
    logic [UQR_DW-1:0] r;
    r = '0;
    r[UQR_CTL_RUN] = c.run;
    r[UQR_CTL_EN] = c.en;
    r[UQR_CTL_MATCH] = c.match_en;
    r[UQR_CTL_OVR] = c.ovr_en;
    r[UQR_CTL_WRAP] = c.wrap_en;
    r[UQR_CTL_PBYTE] = c.pbyte_en;
    r[UQR_CTL_PCTL] = c.pause_ctl;
    return r;
  endfunction : uqr_ctrl_pack

  // Freeze pin and both pause sources all hold the queue
  assign pause = s.pause_bit | s.pause_ctl | ~i_emul_freeze_n;

  // A byte is moved only when enabled, started, waiting and not paused
  assign take = (s.st == UQR_IDLE) && s.run && s.en && s.pending && !pause;

  assign is_match = s.match_en && (i_uart_rx_holding == s.match);

  always_comb begin
    next_s = s;
    ev = '0;
    ev_clr = '0;
    mask_we = 1'b0;
    next_s.fetch = 1'b0;
    next_s.ram_we = 1'b0;

    // One character is held; a second one before it is taken is lost
    if (i_rx_char) begin
      next_s.pending = 1'b1;
      if (s.pending && !take) begin
        ev[UQR_ST_LOST] = 1'b1;
      end
    end else if (take) begin
      next_s.pending = 1'b0;
    end

    if (i_wr) begin
      unique case (i_addr)
        UQR_OFS_CTRL: begin
          // Mode bits, enable and start all land in the same write
          next_s.run = i_wdata[UQR_CTL_RUN];
          next_s.en = i_wdata[UQR_CTL_EN];
          next_s.match_en = i_wdata[UQR_CTL_MATCH];
          next_s.ovr_en = i_wdata[UQR_CTL_OVR];
          next_s.wrap_en = i_wdata[UQR_CTL_WRAP];
          next_s.pbyte_en = i_wdata[UQR_CTL_PBYTE];
          next_s.pause_ctl = i_wdata[UQR_CTL_PCTL];
        end
        UQR_OFS_STAT: begin
          ev_clr = i_wdata[UQR_NEV-1:0];
        end
        UQR_OFS_MASK: begin
          mask_we = 1'b1;
        end
        UQR_OFS_ADDR: begin
          // Start address kept aside for the circular reload
          next_s.addr = i_wdata[AW-1:0];
          next_s.base = i_wdata[AW-1:0];
        end
        UQR_OFS_COUNT: begin
          next_s.count = i_wdata;
          next_s.len = i_wdata;
        end
        UQR_OFS_MATCH: begin
          next_s.match = i_wdata;
        end
        UQR_OFS_PAUSE: begin
          next_s.pause_bit = i_wdata[UQR_PAUSE_BIT];
        end
        default: begin
        end
      endcase
    end

    // Engine updates follow bus writes so a running transfer stays coherent
    unique case (s.st)
      UQR_IDLE: begin
        if (take) begin
          next_s.fetch = 1'b1;
          next_s.ram_we = 1'b1;
          next_s.ram_addr = s.addr;
          next_s.ram_wdata = i_uart_rx_holding;
          next_s.addr = AW'(uqr_step(8'(s.addr), 1'b1));
          next_s.count = uqr_step(s.count, 1'b0);
          if (is_match) begin
            // Stop on the terminator regardless of count
            ev[UQR_ST_DONE] = 1'b1;
            ev[UQR_ST_HIT] = 1'b1;
            next_s.run = 1'b0;
          end else begin
            if (s.pbyte_en) begin
              ev[UQR_ST_DONE] = 1'b1;
            end
            next_s.st = UQR_CHECK;
          end
        end else if (pause && s.run && s.en && s.pending) begin
          // Held byte parks in the wait state until the pause lifts
          next_s.st = UQR_WAIT;
          next_s.from_idle = 1'b1;
        end
      end
      UQR_CHECK: begin
        if (pause) begin
          next_s.st = UQR_WAIT;
        end else begin
          next_s.st = UQR_IDLE;
          if (s.count == 8'h00) begin
            ev[UQR_ST_DONE] = 1'b1;
            if (s.wrap_en) begin
              next_s.addr = s.base;
              next_s.count = s.len;
            end else if (!s.ovr_en && !s.pause_ctl) begin
              // Continue mode and pause control both keep the run flag
              next_s.run = 1'b0;
            end
          end
        end
      end
      UQR_WAIT: begin
        // Count is evaluated only once the pause lifts
        if (!pause) begin
          // No byte moved yet when parked from idle, so skip the count test
          if (s.from_idle) begin
            next_s.st = UQR_IDLE;
          end else begin
            next_s.st = UQR_CHECK;
          end
          next_s.from_idle = 1'b0;
        end
      end
    endcase

    if (!next_s.en) begin
      next_s.run = 1'b0;
    end

    if (i_rd) begin
      unique case (i_addr)
        UQR_OFS_CTRL: begin
          next_s.rdata = uqr_ctrl_pack(s);
        end
        UQR_OFS_STAT: begin
          next_s.rdata = UQR_DW'(status);
          next_s.rdata[UQR_ST_WAIT] = (s.st == UQR_WAIT);
        end
        UQR_OFS_MASK: begin
          next_s.rdata = UQR_DW'(mask);
        end
        UQR_OFS_ADDR: begin
          // Live pointer, not the wrap base
          next_s.rdata = UQR_DW'(s.addr);
        end
        UQR_OFS_COUNT: begin
          // Live count, not the reload length
          next_s.rdata = s.count;
        end
        UQR_OFS_MATCH: begin
          next_s.rdata = s.match;
        end
        UQR_OFS_PAUSE: begin
          next_s.rdata = UQR_DW'(s.pause_bit);
        end
        default: begin
          // Unmapped index reads as zero
          next_s.rdata = '0;
        end
      endcase
    end else begin
      // Read data valid only in the cycle after the strobe
      next_s.rdata = '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s <= UQR_CORE_RST;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  uqr_irq #(
    .NEV(UQR_NEV)
  ) u_irq (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_set(ev),
    .i_clr(ev_clr),
    .i_mask_we(mask_we),
    .i_mask_wdata(i_wdata[UQR_NEV-1:0]),
    .o_status(status),
    .o_mask(mask),
    .o_irq(o_irq)
  );

  assign o_rdata = s.rdata;
  assign o_rx_fetch = s.fetch;
  assign o_ram_we = s.ram_we;
  assign o_ram_addr = s.ram_addr;
  assign o_ram_wdata = s.ram_wdata;
  assign o_rx_done_flag = status[UQR_ST_DONE];
  assign o_rx_run_flag = s.run;
  assign o_rx_waiting = (s.st == UQR_WAIT);

endmodule : uqr_core

/* File: hw/uqr_pkg.sv */
// Shared constants and types for the receive queue controller
package uqr_pkg;

  // Register bus geometry
  localparam int UQR_AW = 4;
  localparam int UQR_DW = 8;

  // Register offsets
  localparam logic [UQR_AW-1:0] UQR_OFS_CTRL = 4'h0;
  localparam logic [UQR_AW-1:0] UQR_OFS_STAT = 4'h1;
  localparam logic [UQR_AW-1:0] UQR_OFS_MASK = 4'h2;
  localparam logic [UQR_AW-1:0] UQR_OFS_ADDR = 4'h3;
  localparam logic [UQR_AW-1:0] UQR_OFS_COUNT = 4'h4;
  localparam logic [UQR_AW-1:0] UQR_OFS_MATCH = 4'h5;
  localparam logic [UQR_AW-1:0] UQR_OFS_PAUSE = 4'h6;

  // Control register field positions
  localparam int UQR_CTL_RUN = 0;
  localparam int UQR_CTL_EN = 1;
  localparam int UQR_CTL_MATCH = 2;
  localparam int UQR_CTL_OVR = 3;
  localparam int UQR_CTL_WRAP = 4;
  localparam int UQR_CTL_PBYTE = 5;
  localparam int UQR_CTL_PCTL = 6;

  // Pause register field position
  localparam int UQR_PAUSE_BIT = 0;

  // Status and mask field positions
  localparam int UQR_NEV = 3;
  localparam int UQR_ST_DONE = 0;
  localparam int UQR_ST_LOST = 1;
  localparam int UQR_ST_HIT = 2;
  localparam int UQR_ST_WAIT = 4;

  // Reset values
  localparam logic [UQR_DW-1:0] UQR_CTRL_RST = 8'h00;
  localparam logic [UQR_DW-1:0] UQR_ADDR_RST = 8'h00;
  localparam logic [UQR_DW-1:0] UQR_COUNT_RST = 8'h00;
  localparam logic [UQR_DW-1:0] UQR_MATCH_RST = 8'h00;
  localparam logic [UQR_NEV-1:0] UQR_MASK_RST = 3'h0;

  typedef enum logic [1:0] {
    UQR_IDLE,
    UQR_CHECK,
    UQR_WAIT
  } uqr_state_e;

endpackage : uqr_pkg

/* File: hw/uqr_irq.sv */
// Sticky event status, mask and level interrupt output
`timescale 1ns/1ps
module uqr_irq #(
  parameter int NEV = 3
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [NEV-1:0] i_set,
  input wire logic [NEV-1:0] i_clr,
  input wire logic i_mask_we,
  input wire logic [NEV-1:0] i_mask_wdata,
  output logic [NEV-1:0] o_status,
  output logic [NEV-1:0] o_mask,
  output logic o_irq
);
  import uqr_pkg::*;

  typedef struct packed {
    logic [NEV-1:0] status;
    logic [NEV-1:0] mask;
  } uqr_irq_s;

  uqr_irq_s s;
  uqr_irq_s next_s;

  always_comb begin
    next_s = s;
    // A set in the clearing cycle wins
    next_s.status = (s.status & ~i_clr) | i_set;
    if (i_mask_we) begin
      next_s.mask = i_mask_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s <= '{status: '0, mask: NEV'(UQR_MASK_RST)};
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_status = s.status;
  assign o_mask = s.mask;
  assign o_irq = |(s.status & s.mask);

endmodule : uqr_irq

/* File: bench/uqr_far.sv */
// Far-side model: UART receiver and internal RAM
`timescale 1ns/1ps
module uqr_far (
  input wire logic i_core_clk,
  input wire logic i_rx_fetch,
  input wire logic i_ram_we,
  input wire logic [7:0] i_ram_addr,
  input wire logic [7:0] i_ram_wdata,
  output logic o_rx_char,
  output logic [7:0] o_holding
);
  logic [7:0] mem [256];
  initial begin
    o_rx_char = 1'b0;
    o_holding = 8'h00;
  end
  task automatic send(input logic [7:0] b);
    @(posedge i_core_clk);
    o_rx_char <= 1'b1;
    o_holding <= b;
    @(posedge i_core_clk);
    o_rx_char <= 1'b0;
  endtask : send
  // Read-out byte turns stale, so a late fetch shows wrong data
  always @(posedge i_core_clk) begin
    if (i_rx_fetch) begin
      o_holding <= ~o_holding;
    end
    if (i_ram_we) begin
      mem[i_ram_addr] <= i_ram_wdata;
    end
  end
endmodule : uqr_far

/* File: bench/uqr_chk_checker.sv */
// Port checks for the receive queue controller
`timescale 1ns/1ps
module uqr_chk (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [uqr_pkg::UQR_AW-1:0] i_addr,
  input wire logic [uqr_pkg::UQR_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic [7:0] i_uart_rx_holding,
  input wire logic o_rx_fetch,
  input wire logic o_ram_we,
  input wire logic [7:0] o_ram_wdata,
  input wire logic i_emul_freeze_n,
  input wire logic o_rx_done_flag,
  input wire logic o_rx_run_flag,
  input wire logic o_rx_waiting,
  input wire logic o_irq
);
  import uqr_pkg::*;
  logic ctl_wr;
  assign ctl_wr = i_wr && i_addr == UQR_OFS_CTRL;
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  pair_a: assert property (o_rx_fetch == o_ram_we)
    else $error("fetch and store apart");
  byte_a: assert property (o_ram_we |-> o_ram_wdata == $past(i_uart_rx_holding))
    else $error("stored byte wrong");
  pace_a: assert property (o_ram_we |=> !o_ram_we)
    else $error("stores too close");
  done_a: assert property ($rose(o_rx_done_flag) |-> o_ram_we || $past(o_ram_we))
    else $error("done without store");
  wait_a: assert property (o_rx_waiting |-> !o_ram_we)
    else $error("store while waiting");
  freeze_a: assert property (!i_emul_freeze_n |=> !o_ram_we)
    else $error("store while frozen");
  stop_a: assert property (ctl_wr && !i_wdata[UQR_CTL_EN] |=> !o_rx_run_flag)
    else $error("run kept after disable");
  start_a: assert property (ctl_wr && i_wdata[UQR_CTL_RUN] && i_wdata[UQR_CTL_EN]
    && !o_ram_we |=> o_rx_run_flag) else $error("run not started");
  cover property (o_ram_we);
  cover property (o_rx_waiting);
  cover property (o_irq);
endmodule : uqr_chk
bind uqr_core uqr_chk u_chk (.*);

/* File: bench/uqr_core_tb.sv */
// Self-checking bench for the receive queue controller
`timescale 1ns/1ps
module uqr_core_tb;
  import uqr_pkg::*;
  localparam logic [7:0] RE = 8'h03;
  logic clk, rst_n, wr, rd, frz_n, rxc, fetch, we, done, run, waiting, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, hold, ram_a, ram_d;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  uqr_core #(.AW(8)) dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_char(rxc),
    .i_uart_rx_holding(hold), .o_rx_fetch(fetch), .o_ram_we(we), .o_ram_addr(ram_a),
    .o_ram_wdata(ram_d), .i_emul_freeze_n(frz_n), .o_rx_done_flag(done),
    .o_rx_run_flag(run), .o_rx_waiting(waiting), .o_irq(irq));
  // UART side stands configured from time zero
  uqr_far u_far (.i_core_clk(clk), .i_rx_fetch(fetch), .i_ram_we(we), .i_ram_addr(ram_a),
    .i_ram_wdata(ram_d), .o_rx_char(rxc), .o_holding(hold));
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic flags(input logic [2:0] e);
    #1;
    cmp({5'h0, done, run, irq}, {5'h0, e});
  endtask : flags
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask : rreg
  task automatic setup(input logic [7:0] a, input logic [7:0] n, input logic [7:0] c);
    wreg(UQR_OFS_ADDR, a);
    wreg(UQR_OFS_COUNT, n);
    wreg(UQR_OFS_CTRL, c);
  endtask : setup
  // Bounded wait for a RAM store, then check the stored byte
  task automatic land(input logic [7:0] b, input logic [7:0] a);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (we !== 1'b1 && n < 40);
    #1;
    cmp(u_far.mem[a], b);
  endtask : land
  task automatic put(input logic [7:0] b, input logic [7:0] a);
    u_far.send(b);
    land(b, a);
  endtask : put
  task automatic t_normal();
    wreg(UQR_OFS_MASK, 8'h01);
    setup(8'hfe, 8'h03, RE);
    put(8'h5a, 8'hfe);
    flags(3'b010);
    put(8'ha5, 8'hff);
    put(8'h3c, 8'h00);
    flags(3'b101);
    rreg(UQR_OFS_COUNT, 8'h00);
    rreg(UQR_OFS_ADDR, 8'h01);
    rreg(4'hf, 8'h00);
    wreg(UQR_OFS_MASK, 8'h00);
    flags(3'b100);
    wreg(UQR_OFS_MASK, 8'h07);
    wreg(UQR_OFS_STAT, 8'h01);
    flags(3'b000);
  endtask : t_normal
  task automatic t_modes();
    wreg(UQR_OFS_MATCH, 8'h0d);
    setup(8'h10, 8'h05, RE | 8'h04);
    put(8'h41, 8'h10);
    put(8'h0d, 8'h11);
    flags(3'b101);
    rreg(UQR_OFS_STAT, 8'h05);
    rreg(UQR_OFS_COUNT, 8'h03);
    wreg(UQR_OFS_STAT, 8'h07);
    setup(8'h20, 8'h01, RE | 8'h08);
    put(8'h11, 8'h20);
    flags(3'b111);
    put(8'h22, 8'h21);
    wreg(UQR_OFS_CTRL, 8'h00);
    flags(3'b101);
    wreg(UQR_OFS_STAT, 8'h07);
    setup(8'h30, 8'h02, RE | 8'h10);
    put(8'h31, 8'h30);
    put(8'h32, 8'h31);
    cmp({7'h0, done}, 8'h01);
    put(8'h33, 8'h30);
    rreg(UQR_OFS_COUNT, 8'h01);
    wreg(UQR_OFS_CTRL, 8'h00);
    wreg(UQR_OFS_STAT, 8'h07);
  endtask : t_modes
  task automatic t_pause();
    wreg(UQR_OFS_PAUSE, 8'h01);
    setup(8'h40, 8'h03, RE | 8'h20);
    u_far.send(8'h44);
    repeat (4) @(posedge clk);
    #1;
    cmp({7'h0, waiting}, 8'h01);
    wreg(UQR_OFS_PAUSE, 8'h00);
    land(8'h44, 8'h40);
    flags(3'b111);
    wreg(UQR_OFS_STAT, 8'h07);
    @(posedge clk);
    frz_n <= 1'b0;
    u_far.send(8'h45);
    repeat (4) @(posedge clk);
    #1;
    cmp({7'h0, waiting}, 8'h01);
    @(posedge clk);
    frz_n <= 1'b1;
    land(8'h45, 8'h41);
    wreg(UQR_OFS_CTRL, 8'h00);
  endtask : t_pause
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    frz_n = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rreg(4'(i), 8'h00);
    end
    t_normal();
    t_modes();
    t_pause();
    give_verdict();
  end
endmodule : uqr_core_tb
